/* File: bench/nvm_unlock_program_erase_ctrl_sva.sv */
// checker for the nvm cpu interface between driver and controller
// assumes one clock, sync low reset, signals taken from the interface
`timescale 1ns/10ps
module nvm_unlock_program_erase_ctrl_sva #(
   parameter int CYCLE_CLKS = 20
) (
   input logic i_clk,
   input logic i_reset_n,
   input logic [15:0] addr,
   input logic [15:0] wdata,
   input logic wr,
   input logic rd,
   input logic tbl_wr,
   input logic tbl_rd,
   input logic stall,
   input logic done_flag,
   input logic done_clr
);
   logic [1:0] key_q;
   logic en_q;
   logic busy_q;
   logic ee_q;
   logic done_q;
   int since_q;
   wire ctrl_w = wr && addr == nvm_ctrl_pkg::OFS_OP_CONTROL;
   wire key_w = wr && addr == nvm_ctrl_pkg::OFS_UNLOCK_KEY;
   wire start_w = ctrl_w && wdata[15];
   wire k1_w = key_w && wdata[7:0] == nvm_ctrl_pkg::KEY_FIRST;
   wire k2_w = key_w && wdata[7:0] == nvm_ctrl_pkg::KEY_SECOND;
   wire ee_w = wdata[6:0] == nvm_ctrl_pkg::OP_EE_BLOCK_ERASE
      || wdata[6:0] == nvm_ctrl_pkg::OP_EE_WORD_ERASE
      || wdata[6:0] == nvm_ctrl_pkg::OP_EE_WORD_PROG
      || wdata[6:0] == nvm_ctrl_pkg::OP_EE_BLOCK_PROG;
   wire ok_w = start_w && key_q == 2'h2 && en_q && !busy_q;
   // any other write disarms, so the model tracks every write
   wire logic [1:0] key_d = !wr ? key_q : k1_w ? 2'h1 :
      (k2_w && key_q == 2'h1) ? 2'h2 : 2'h0;
   wire end_w = (done_flag && !done_q) || since_q >= CYCLE_CLKS + 2;
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         key_q <= 2'h0;
         en_q <= 1'b0;
         busy_q <= 1'b0;
         ee_q <= 1'b0;
         done_q <= 1'b0;
         since_q <= 0;
      end
      else
      begin
         key_q <= key_d;
         done_q <= done_flag;
         since_q <= ok_w ? 1 : since_q + 1;
         en_q <= ctrl_w ? wdata[14] : en_q;
         ee_q <= ok_w ? ee_w : ee_q;
         busy_q <= ok_w ? 1'b1 : (end_w ? 1'b0 : busy_q);
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   a_done_holds: assert property (done_flag && !done_clr |=> done_flag)
      else $error("done flag dropped without clear");
   a_done_clears: assert property (done_clr && !busy_q |=> !done_flag)
      else $error("done flag not cleared");
   a_done_timing: assert property ($rose(done_flag) |->
      busy_q && since_q <= CYCLE_CLKS + 1)
      else $error("done flag without an accepted start");
   a_ee_no_stall: assert property (busy_q && ee_q |-> !stall)
      else $error("stall during eeprom cycle");
   a_flash_stall: assert property (ok_w && !ee_w |=> stall)
      else $error("no stall on flash operation");
   a_two_idle: assert property (start_w |=>
      !(wr || rd || tbl_wr || tbl_rd) [*2])
      else $error("access right after start");
   a_key_order: assert property (k1_w |=> k2_w ##1 start_w)
      else $error("key sequence broken");
   a_no_busy_start: assert property (busy_q |-> !start_w)
      else $error("start while busy");
endmodule

/* File: bench/tb_nvm_unlock_program_erase_ctrl.sv */
// testbench: cpu driver and controller joined by the interface
// assumes both ends come from src and share one clock
`timescale 1ns/10ps
module tb_nvm_unlock_program_erase_ctrl;
   localparam int CYC = 20;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic pwr = 1'b1;
   logic early = 1'b0;
   logic go = 1'b0;
   logic clr = 1'b0;
   logic twr = 1'b0;
   logic trd = 1'b0;
   logic [6:0] op = 7'h00;
   logic [22:0] addr = 23'h000000;
   logic [15:0] twd = 16'h0000;
   logic ready, done, busy, fstart;
   logic fs_seen = 1'b0;
   logic st_seen = 1'b0;
   logic [15:0] trdata;
   logic [15:0] blk [16];
   logic [31:0] lfsr_q = 32'h3D28;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   nvm_cpu_if bus_if ();
   wire [15:0] ctrl_seen = nvm_unlock_program_erase_ctrl_inst.ctrl_q;
   wire [15:0] adr_seen = nvm_unlock_program_erase_ctrl_inst.adr_low_q;
   wire wen_seen = ctrl_seen[nvm_ctrl_pkg::BIT_WRITE_ENABLE];
   wire err_seen = ctrl_seen[nvm_ctrl_pkg::BIT_WRITE_ERROR];
   nvm_unlock_program_erase_ctrl #(.CYCLE_CLKS(CYC))
      nvm_unlock_program_erase_ctrl_inst (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_power_on(pwr), .i_cycle_done_early(early),
      .bus(bus_if.device), .o_busy(busy), .o_flash_start(fstart));
   nvm_cpu_driver nvm_cpu_driver_inst (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .i_go(go), .i_op(op), .i_addr(addr),
      .i_clear_done(clr), .i_tbl_wr(twr), .i_tbl_rd(trd),
      .i_tbl_wdata(twd), .bus(bus_if.cpu), .o_ready(ready),
      .o_done(done), .o_tbl_rdata(trdata));
   nvm_unlock_program_erase_ctrl_sva #(.CYCLE_CLKS(CYC)) sva_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
      .tbl_wr(bus_if.tbl_wr), .tbl_rd(bus_if.tbl_rd),
      .stall(bus_if.stall), .done_flag(bus_if.done_flag),
      .done_clr(bus_if.done_clr));
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      fs_seen <= (i_reset_n && fstart === 1'b1) ? 1'b1 : fs_seen;
      st_seen <= (bus_if.stall === 1'b1) ? 1'b1 : st_seen;
      // generous ceiling: the full run needs well under a thousand cycles
      if (cycles == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[15:0];
   endfunction
   task chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task chk1(input string n, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %b got %b", n, e, g);
      end
   endtask
   task tbl_write(input logic [22:0] a, input logic [15:0] d);
      @(posedge i_clk);
      twr <= 1'b1;
      addr <= a;
      twd <= d;
      @(posedge i_clk);
      twr <= 1'b0;
   endtask
   task tbl_read(input logic [22:0] a, input logic [15:0] e);
      @(posedge i_clk);
      trd <= 1'b1;
      addr <= a;
      @(posedge i_clk);
      trd <= 1'b0;
      // driver registers the request and the answer: two more edges
      repeat (2) @(posedge i_clk);
      #1 chk16("tbl_rdata", e, trdata);
   endtask
   // e > 0 ends the cycle early that many clocks after go
   task run_op(input logic [6:0] o, input logic [22:0] a, input int e);
      repeat (40) if (ready !== 1'b1) @(posedge i_clk) #1;
      @(posedge i_clk);
      go <= 1'b1;
      op <= o;
      addr <= a;
      @(posedge i_clk);
      go <= 1'b0;
      if (e > 0)
      begin
         repeat (e) @(posedge i_clk);
         early <= 1'b1;
         @(posedge i_clk);
         early <= 1'b0;
      end
      #1;
      repeat (e > 0 ? 4 : CYC + 30) if (done !== 1'b1) @(posedge i_clk) #1;
      chk1("done", 1'b1, done);
      chk1("busy_end", 1'b0, busy);
      chk1("wen_kept", 1'b1, wen_seen);
      // the driver clears the flag two edges after it rises
      @(posedge i_clk);
      #1 chk1("done_held", 1'b1, done);
      @(posedge i_clk);
      clr <= 1'b1;
      @(posedge i_clk);
      clr <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 chk1("done_clr", 1'b0, done);
      repeat (40) if (ready !== 1'b1) @(posedge i_clk) #1;
   endtask
   task complete_run();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      logic [8:0] idx;
      logic [22:0] a;
      logic [15:0] d;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      #1 chk1("busy", 1'b0, busy);
      chk1("done", 1'b0, done);
      chk1("wen_pwrup", 1'b0, wen_seen);
      for (int i = 0; i < 4; i++)
      begin
         idx = i == 0 ? 9'h000 : (i == 1 ? 9'h1FF : 9'(rnd()));
         a = nvm_ctrl_pkg::EE_BASE + {13'h0000, idx, 1'b0};
         d = rnd();
         run_op(nvm_ctrl_pkg::OP_EE_WORD_ERASE, a, 0);
         tbl_read(a, 16'hFFFF);
         tbl_write(a, d);
         run_op(nvm_ctrl_pkg::OP_EE_WORD_PROG, a, i == 3 ? 10 : 0);
         tbl_read(a, d);
      end
      a = nvm_ctrl_pkg::EE_BASE + {13'h0000, 5'(rnd()), 5'h00};
      run_op(nvm_ctrl_pkg::OP_EE_BLOCK_ERASE, a, 0);
      tbl_read(a + 23'h00001E, 16'hFFFF);
      for (int k = 0; k < 16; k++)
      begin
         blk[k] = rnd();
         tbl_write(a + 23'(2 * k), blk[k]);
      end
      run_op(nvm_ctrl_pkg::OP_EE_BLOCK_PROG, a, 0);
      for (int k = 0; k < 16; k++)
         tbl_read(a + 23'(2 * k), blk[k]);
      // warm reset in mid-cycle: error flagged, address kept for retry
      a = nvm_ctrl_pkg::EE_BASE + {13'h0000, 9'(rnd()), 1'b0};
      @(posedge i_clk);
      go <= 1'b1;
      op <= nvm_ctrl_pkg::OP_EE_WORD_ERASE;
      addr <= a;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (12) @(posedge i_clk);
      pwr <= 1'b0;
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      pwr <= 1'b1;
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      #1 chk1("wr_error", 1'b1, err_seen);
      chk16("adr_kept", a[15:0], adr_seen);
      chk1("busy_rst", 1'b0, busy);
      chk1("ready_rst", 1'b1, ready);
      run_op(nvm_ctrl_pkg::OP_EE_WORD_ERASE, a, 0);
      chk1("err_clr", 1'b0, err_seen);
      tbl_read(a, 16'hFFFF);
      chk1("ee_stall", 1'b0, st_seen);
      run_op(7'h01, 23'h000100, 0);
      chk1("flash_start", 1'b1, fs_seen);
      chk1("stall", 1'b1, st_seen);
      complete_run();
   end
endmodule

/* File: src/nvm_cpu_driver.sv */
// cpu-side end: turns user commands into register and table accesses
// assumes the controller end sits on the same interface and clock
`timescale 1ns/10ps
module nvm_cpu_driver (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_go,
   input wire logic [6:0] i_op,
   input wire logic [22:0] i_addr,
   input wire logic i_clear_done,
   input wire logic i_tbl_wr,
   input wire logic i_tbl_rd,
   input wire logic [15:0] i_tbl_wdata,
   nvm_cpu_if.cpu bus,
   output logic o_ready,
   output logic o_done,
   output logic [15:0] o_tbl_rdata
);
   typedef enum logic [3:0]
   {
      S_IDLE = 4'b0000,
      S_CTRL = 4'b0001,
      S_ADRH = 4'b0010,
      S_ADRL = 4'b0011,
      S_KEY1 = 4'b0100,
      S_KEY2 = 4'b0101,
      S_START = 4'b0110,
      S_NOP1 = 4'b0111,
      S_NOP2 = 4'b1000,
      S_WAIT = 4'b1001,
      S_DISABLE = 4'b1010
   } drv_state_t;

   drv_state_t st_q, st_d;
   logic [6:0] op_q;
   logic [22:0] addr_q;
   logic [15:0] addr_d;
   logic [15:0] wdata_d;
   logic wr_d;
   logic [15:0] ctl_word;

   assign ctl_word = {1'b0, 1'b1, 7'h00, op_q};

   // the sequence runs without gaps, so nothing else can intervene
   always_comb
   begin
      st_d = st_q;
      addr_d = 16'h0000;
      wdata_d = 16'h0000;
      wr_d = 1'b0;
      case (st_q)
         S_IDLE: if (i_go && !bus.stall) st_d = S_CTRL;
         S_CTRL:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_OP_CONTROL;
            wdata_d = ctl_word;
            st_d = S_ADRH;
         end
         S_ADRH:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_ADDR_HIGH;
            wdata_d = {9'h000, addr_q[22:16]};
            st_d = S_ADRL;
         end
         S_ADRL:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_ADDR_LOW;
            wdata_d = addr_q[15:0];
            st_d = S_KEY1;
         end
         S_KEY1:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_UNLOCK_KEY;
            wdata_d = {8'h00, nvm_ctrl_pkg::KEY_FIRST};
            st_d = S_KEY2;
         end
         S_KEY2:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_UNLOCK_KEY;
            wdata_d = {8'h00, nvm_ctrl_pkg::KEY_SECOND};
            st_d = S_START;
         end
         S_START:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_OP_CONTROL;
            wdata_d = ctl_word | 16'h8000;
            st_d = S_NOP1;
         end
         S_NOP1: st_d = S_NOP2;
         S_NOP2: st_d = S_WAIT;
         S_WAIT: if (bus.done_flag) st_d = S_DISABLE;
         S_DISABLE:
         begin
            wr_d = 1'b1;
            addr_d = nvm_ctrl_pkg::OFS_OP_CONTROL;
            wdata_d = {9'h000, op_q};
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         st_q <= S_IDLE;
         op_q <= 7'h00;
         addr_q <= 23'h000000;
         bus.wr <= 1'b0;
         bus.addr <= 16'h0000;
         bus.wdata <= 16'h0000;
         bus.done_clr <= 1'b0;
         bus.tbl_wr <= 1'b0;
         bus.tbl_rd <= 1'b0;
         bus.tbl_addr <= 23'h000000;
         bus.tbl_wdata <= 16'h0000;
         o_tbl_rdata <= 16'h0000;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == S_IDLE && i_go)
         begin
            op_q <= i_op; // erase-before-program is the user's
            addr_q <= i_addr;
         end
         bus.wr <= wr_d;
         bus.addr <= addr_d;
         bus.wdata <= wdata_d;
         // clears the flag once seen, or on user request
         bus.done_clr <= (st_q == S_WAIT && bus.done_flag) || i_clear_done;
         bus.tbl_wr <= i_tbl_wr && st_q == S_IDLE && !i_go;
         bus.tbl_rd <= i_tbl_rd && st_q == S_IDLE && !i_go;
         bus.tbl_addr <= i_addr;
         bus.tbl_wdata <= i_tbl_wdata;
         o_tbl_rdata <= bus.tbl_rdata;
      end
   end

   assign bus.rd = 1'b0;
   assign o_ready = (st_q == S_IDLE) && !bus.stall;
   assign o_done = bus.done_flag;
endmodule

/* File: src/nvm_cpu_if.sv */
// register and table access path between cpu core and nvm controller
// single clock, requests driven by the cpu end, rdata, tbl_rdata, stall and done_flag by the controller
`timescale 1ns/10ps
interface nvm_cpu_if;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic [22:0] tbl_addr;
   logic [15:0] tbl_wdata;
   logic tbl_wr;
   logic tbl_rd;
   logic [15:0] tbl_rdata;
   logic stall;
   logic done_flag;
   logic done_clr;
   modport device (input addr, wdata, wr, rd, tbl_addr, tbl_wdata, tbl_wr,
      tbl_rd, done_clr, output rdata, tbl_rdata, stall, done_flag);
   modport cpu (output addr, wdata, wr, rd, tbl_addr, tbl_wdata, tbl_wr,
      tbl_rd, done_clr, input rdata, tbl_rdata, stall, done_flag);
endinterface

/* File: src/nvm_ctrl_pkg.sv */
// constants shared by the nvm controller and its cpu-side driver
// assumes a 125 MHz core clock on both ends
package nvm_ctrl_pkg;
   localparam logic [15:0] OFS_OP_CONTROL = 16'h0760;
   localparam logic [15:0] OFS_ADDR_LOW = 16'h0762;
   localparam logic [15:0] OFS_ADDR_HIGH = 16'h0764;
   localparam logic [15:0] OFS_UNLOCK_KEY = 16'h0766;
   localparam int BIT_WRITE_START = 15;
   localparam int BIT_WRITE_ENABLE = 14;
   localparam int BIT_WRITE_ERROR = 13;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RW_MASK = 16'h407F;
   localparam logic [15:0] HIGH_RW_MASK = 16'h007F;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // operation select encodings
   localparam logic [6:0] OP_EE_BLOCK_ERASE = 7'h45;
   localparam logic [6:0] OP_EE_WORD_ERASE = 7'h44;
   localparam logic [6:0] OP_EE_WORD_PROG = 7'h04;
   localparam logic [6:0] OP_EE_BLOCK_PROG = 7'h0A;
   localparam int BIT_OP_DATA_EE = 2;
   localparam int EE_WORDS = 512;
   localparam int EE_BLOCK_WORDS = 16;
   localparam logic [22:0] EE_BASE = 23'h7FFC00;
   localparam logic [22:0] EE_LAST = 23'h7FFFFE;
   localparam int CLK_MHZ = 125;
   localparam int CYCLE_TIME_US = 2000;
   localparam int CYCLE_COUNT = CYCLE_TIME_US * CLK_MHZ;
endpackage

/* File: src/nvm_unlock_program_erase_ctrl.sv */
// nvm controller: unlock keys, write/erase sequencing, data eeprom array
// assumes the cpu end owns the interface; one clock, sync low reset
`timescale 1ns/10ps
module nvm_unlock_program_erase_ctrl #(
   parameter int CYCLE_CLKS = nvm_ctrl_pkg::CYCLE_COUNT
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_power_on,
   input wire logic i_cycle_done_early,
   nvm_cpu_if.device bus,
   output logic o_busy,
   output logic o_flash_start
);
   typedef enum logic [1:0]
   {
      KEY_IDLE = 2'b00,
      KEY_GOT_FIRST = 2'b01,
      KEY_ARMED = 2'b10
   } key_state_t;

   key_state_t key_q, key_d;
   logic [15:0] ctrl_q;
   logic [15:0] adr_low_q;
   logic [15:0] adr_high_q;
   logic [17:0] count_q;
   logic [15:0] ee_mem [0:nvm_ctrl_pkg::EE_WORDS-1];
   logic [15:0] latch [0:nvm_ctrl_pkg::EE_BLOCK_WORDS-1];
   logic [15:0] rdata_q;
   logic [15:0] tbl_rdata_q;
   logic done_flag_q;

   function automatic logic [8:0] ee_index(input logic [22:0] a);
      ee_index = a[9:1];
   endfunction

   function automatic logic in_ee(input logic [22:0] a);
      in_ee = (a >= nvm_ctrl_pkg::EE_BASE) && (a <= nvm_ctrl_pkg::EE_LAST);
   endfunction

   // no single select bit marks the eeprom: block program lacks bit 2
   function automatic logic ee_op(input logic [6:0] o);
      ee_op = (o == nvm_ctrl_pkg::OP_EE_BLOCK_ERASE)
         || (o == nvm_ctrl_pkg::OP_EE_WORD_ERASE)
         || (o == nvm_ctrl_pkg::OP_EE_WORD_PROG)
         || (o == nvm_ctrl_pkg::OP_EE_BLOCK_PROG);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire wr_ctrl = bus.wr && (bus.addr == nvm_ctrl_pkg::OFS_OP_CONTROL);
   wire wr_low = bus.wr && (bus.addr == nvm_ctrl_pkg::OFS_ADDR_LOW);
   wire wr_high = bus.wr && (bus.addr == nvm_ctrl_pkg::OFS_ADDR_HIGH);
   wire wr_key = bus.wr && (bus.addr == nvm_ctrl_pkg::OFS_UNLOCK_KEY);
   wire busy = ctrl_q[nvm_ctrl_pkg::BIT_WRITE_START];
   wire wen_now = ctrl_q[nvm_ctrl_pkg::BIT_WRITE_ENABLE];
   // old write enable must already be set; same-write set is refused
   wire start_ok = wr_ctrl && bus.wdata[nvm_ctrl_pkg::BIT_WRITE_START]
      && !busy && wen_now && (key_q == KEY_ARMED);
   wire [6:0] op_sel = ctrl_q[6:0];
   wire is_ee = ee_op(op_sel);
   wire [22:0] target = {adr_high_q[6:0], adr_low_q};
   wire [8:0] tgt_idx = ee_index(target);
   wire [8:0] blk_idx = {tgt_idx[8:4], 4'h0};
   wire cycle_end = busy && ((count_q == 18'(CYCLE_CLKS - 1))
      || i_cycle_done_early);
   wire tbl_ee = in_ee(bus.tbl_addr);

   ////////////////////////////////////////////////////////////////////////
   // unlock sequencer
   always_comb
   begin
      key_d = key_q;
      if (start_ok)
         key_d = KEY_IDLE;
      else if (wr_key && bus.wdata[7:0] == nvm_ctrl_pkg::KEY_FIRST)
         key_d = KEY_GOT_FIRST;
      else if (wr_key && key_q == KEY_GOT_FIRST
         && bus.wdata[7:0] == nvm_ctrl_pkg::KEY_SECOND)
         key_d = KEY_ARMED;
      else if (bus.wr)
         key_d = KEY_IDLE;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         key_q <= KEY_IDLE;
      else
         key_q <= key_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // control register and cycle timer
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         // warm reset mid-cycle flags the error and keeps it over a long
         // reset; power-up clears all
         ctrl_q <= nvm_ctrl_pkg::CTRL_RESET;
         if (!i_power_on)
            ctrl_q[nvm_ctrl_pkg::BIT_WRITE_ERROR] <= busy
               || ctrl_q[nvm_ctrl_pkg::BIT_WRITE_ERROR];
         count_q <= '0;
      end
      else
      begin
         if (wr_ctrl && !busy)
            // enable may drop mid-cycle, op select is frozen while busy
            ctrl_q[6:0] <= bus.wdata[6:0];
         if (wr_ctrl)
         begin
            ctrl_q[nvm_ctrl_pkg::BIT_WRITE_ENABLE] <=
               bus.wdata[nvm_ctrl_pkg::BIT_WRITE_ENABLE];
            ctrl_q[nvm_ctrl_pkg::BIT_WRITE_ERROR] <=
               bus.wdata[nvm_ctrl_pkg::BIT_WRITE_ERROR];
         end
         if (start_ok)
            ctrl_q[nvm_ctrl_pkg::BIT_WRITE_START] <= 1'b1;
         else if (cycle_end)
            ctrl_q[nvm_ctrl_pkg::BIT_WRITE_START] <= 1'b0;
         count_q <= busy && !cycle_end ? count_q + 18'h00001 : 18'h00000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address registers: not reset, kept across reset for retry
   always_ff @(posedge i_clk)
   begin
      if (wr_low && !busy)
         adr_low_q <= bus.wdata;
      else if ((bus.tbl_wr || bus.tbl_rd) && !busy)
         adr_low_q <= bus.tbl_addr[15:0];
      if (wr_high && !busy)
         adr_high_q <= bus.wdata & nvm_ctrl_pkg::HIGH_RW_MASK;
      else if ((bus.tbl_wr || bus.tbl_rd) && !busy)
         adr_high_q <= {9'h000, bus.tbl_addr[22:16]};
   end

   ////////////////////////////////////////////////////////////////////////
   // eeprom array, latches and table path
   always_ff @(posedge i_clk)
   begin
      if (bus.tbl_wr && tbl_ee && !busy)
         latch[bus.tbl_addr[4:1]] <= bus.tbl_wdata;
      if (cycle_end && is_ee)
      begin
         for (int i = 0; i < nvm_ctrl_pkg::EE_BLOCK_WORDS; i++)
         begin
            if (op_sel == nvm_ctrl_pkg::OP_EE_BLOCK_ERASE)
               ee_mem[blk_idx + 9'(i)] <= 16'hFFFF;
            else if (op_sel == nvm_ctrl_pkg::OP_EE_BLOCK_PROG)
               ee_mem[blk_idx + 9'(i)] <= latch[i];
         end
         if (op_sel == nvm_ctrl_pkg::OP_EE_WORD_ERASE)
            ee_mem[tgt_idx] <= 16'hFFFF;
         else if (op_sel == nvm_ctrl_pkg::OP_EE_WORD_PROG)
            ee_mem[tgt_idx] <= latch[tgt_idx[3:0]];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         rdata_q <= 16'h0000;
         tbl_rdata_q <= 16'h0000;
         done_flag_q <= 1'b0;
      end
      else
      begin
         rdata_q <= 16'h0000;
         if (bus.rd && bus.addr == nvm_ctrl_pkg::OFS_OP_CONTROL)
            rdata_q <= ctrl_q;
         else if (bus.rd && bus.addr == nvm_ctrl_pkg::OFS_ADDR_LOW)
            rdata_q <= adr_low_q;
         else if (bus.rd && bus.addr == nvm_ctrl_pkg::OFS_ADDR_HIGH)
            rdata_q <= adr_high_q; // key reads zero
         if (bus.tbl_rd)
            // data during a cycle is unspecified; here all ones
            tbl_rdata_q <= busy || !tbl_ee ? 16'hFFFF
               : ee_mem[ee_index(bus.tbl_addr)];
         if (cycle_end)
            done_flag_q <= 1'b1;
         else if (bus.done_clr)
            done_flag_q <= 1'b0;
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.tbl_rdata = tbl_rdata_q;
   assign bus.done_flag = done_flag_q;
   assign bus.stall = busy && !is_ee;
   assign o_busy = busy;
   assign o_flash_start = start_ok && !is_ee;
endmodule
